/* File: logic/lps_status_ports.sv */
/*
 * Light pen status ports with base decode and strapped sync options.
 * Assumes an I/O bus with active-low read and write strobes whose address
 * is stable around the strobe, a light pen on pins, and a pixel enable pulse
 * plus mode status bits from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Eight-bit read-only status at offset ten
// - Bits zero, three follow colour or mono
// - Pen trigger sets latch bit one
// - Reset and clear command clear latch
// - Bit two follows switch, unlatched
// - Bits four to seven give pixel count captured at pen hit while latch is clear
// - Any access at offset eleven clears
// - Any access at offset twelve sets
// - Offsets thirteen to fifteen do nothing
// - Default bases 3B0 and 3D0
// - Four straps cut base weights
// - Sync polarities default, strap invertible
// - Composite sources and sync-on-green strapped
module lps_status_ports (
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst,
	input  wire logic [9:0]           i_io_addr,
	input  wire logic                 i_io_rd_n,
	input  wire logic                 i_io_wr_n,
	output logic      [7:0]           o_io_data,
	output logic                      o_io_data_oe,
	input  wire logic                 i_pen_trigger,
	input  wire logic                 i_pen_switch_open,
	input  wire logic                 i_pixel_en,
	input  wire logic                 i_color_mode,
	input  wire logic [1:0]           i_color_status,
	input  wire logic [1:0]           i_mono_status,
	input  wire lps_pkg::lps_straps_s i_straps,
	input  wire lps_pkg::lps_video_s  i_video,
	output logic                      o_pen_latched,
	output logic      [3:0]           o_pen_pixel,
	output logic                      o_hsync,
	output logic                      o_vsync,
	output logic                      o_csync,
	output logic                      o_cblank,
	output logic                      o_sync_on_green
);
	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	logic [9:0]           addr_s1;
	logic [9:0]           addr_s2;
	logic                 rd_n_s1;
	logic                 rd_n_s2;
	logic                 wr_n_s1;
	logic                 wr_n_s2;
	logic                 busy_q;
	logic                 pen_s1;
	logic                 pen_s2;
	logic                 pen_q;
	logic                 sw_s1;
	logic                 sw_s2;
	lps_pkg::lps_straps_s straps_s1;
	lps_pkg::lps_straps_s straps_s2;
	logic [9:0]           mono_base;
	logic [9:0]           color_base;
	logic                 base_hit;
	logic [3:0]           offset;
	logic                 rd_act;
	logic                 access;
	logic                 hit_status;
	logic                 hit_clear;
	logic                 hit_set;
	logic                 pen_edge;
	logic                 pen_latch;
	logic [3:0]           pix_cnt;
	logic [3:0]           pen_pos;
	logic [7:0]           next_status;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	// Two flops on every pin before any logic looks at it
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			addr_s1   <= 10'h000;
			addr_s2   <= 10'h000;
			rd_n_s1   <= 1'b1;
			rd_n_s2   <= 1'b1;
			wr_n_s1   <= 1'b1;
			wr_n_s2   <= 1'b1;
			pen_s1    <= 1'b0;
			pen_s2    <= 1'b0;
			sw_s1     <= 1'b0;
			sw_s2     <= 1'b0;
			straps_s1 <= lps_pkg::STRAPS_RST;
			straps_s2 <= lps_pkg::STRAPS_RST;
		end else begin
			addr_s1   <= i_io_addr;
			addr_s2   <= addr_s1;
			rd_n_s1   <= i_io_rd_n;
			rd_n_s2   <= rd_n_s1;
			wr_n_s1   <= i_io_wr_n;
			wr_n_s2   <= wr_n_s1;
			pen_s1    <= i_pen_trigger;
			pen_s2    <= pen_s1;
			sw_s1     <= i_pen_switch_open;
			sw_s2     <= sw_s1;
			straps_s1 <= i_straps;
			straps_s2 <= straps_s1;
		end
	end

	// Edge memory for strobe and pen trigger
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			busy_q <= 1'b0;
			pen_q  <= 1'b0;
		end else begin
			busy_q <= ~rd_n_s2 | ~wr_n_s2;
			pen_q  <= pen_s2;
		end
	end

	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	// strap cuts remove weights
	always_comb begin
		mono_base = lps_pkg::MONO_BASE_DFLT;
		if (straps_s2.base_cut[0]) begin
			mono_base = mono_base - lps_pkg::CUT_WEIGHT_1;
		end
		if (straps_s2.base_cut[1]) begin
			mono_base = mono_base - lps_pkg::CUT_WEIGHT_2;
		end
		if (straps_s2.base_cut[2]) begin
			mono_base = mono_base - lps_pkg::CUT_WEIGHT_3;
		end
		if (straps_s2.base_cut[3]) begin
			mono_base = mono_base - lps_pkg::CUT_WEIGHT_4;
		end
	end

	assign color_base = mono_base + lps_pkg::COLOR_DELTA;
	assign base_hit   = (addr_s2[9:4] == mono_base[9:4]) ||
	                    (addr_s2[9:4] == color_base[9:4]);
	assign offset     = addr_s2[3:0];
	assign rd_act     = ~rd_n_s2;
	assign access     = (~rd_n_s2 | ~wr_n_s2) & ~busy_q;

	// offsets d to f decode to nothing
	always_comb begin
		hit_status = 1'b0;
		hit_clear  = 1'b0;
		hit_set    = 1'b0;
		if (!base_hit) begin
			hit_status = 1'b0;
		end else if (offset == lps_pkg::OFF_STATUS) begin
			hit_status = 1'b1;
		end else if (offset == lps_pkg::OFF_PEN_CLEAR) begin
			hit_clear = 1'b1;
		end else if (offset == lps_pkg::OFF_PEN_SET) begin
			hit_set = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Light pen latch and pixel counter
	// ---------------------------------------------------------------
	assign pen_edge = pen_s2 & ~pen_q;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pix_cnt <= lps_pkg::PIX_CNT_RST;
		end else if (i_pixel_en) begin
			pix_cnt <= pix_cnt + 4'h1;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pen_latch <= lps_pkg::PEN_LATCH_RST;
		end else if (pen_edge || (access && hit_set)) begin
			pen_latch <= 1'b1;
		end else if (access && hit_clear) begin
			pen_latch <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pen_pos <= lps_pkg::PIX_CNT_RST;
		end else if (pen_edge && !pen_latch) begin
			pen_pos <= pix_cnt;
		end
	end

	// ---------------------------------------------------------------
	// Status read path
	// ---------------------------------------------------------------
	// status assembly
	always_comb begin
		next_status = 8'h00;
		next_status[lps_pkg::ST_MODE_LO] = i_color_mode ? i_color_status[0]
		                                                : i_mono_status[0];
		next_status[lps_pkg::ST_MODE_HI] = i_color_mode ? i_color_status[1]
		                                                : i_mono_status[1];
		next_status[lps_pkg::ST_PEN_LATCH]  = pen_latch;
		next_status[lps_pkg::ST_PEN_SWITCH] = sw_s2;
		next_status[7:lps_pkg::ST_PIX_LSB]  = pen_pos;
	end

	// read drives data, no side effect
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_io_data    <= lps_pkg::IO_DATA_RST;
			o_io_data_oe <= 1'b0;
		end else begin
			o_io_data_oe <= rd_act & hit_status;
			if (rd_act && hit_status) begin
				o_io_data <= next_status;
			end
		end
	end

	assign o_pen_latched = pen_latch;
	assign o_pen_pixel   = pen_pos;

	// ---------------------------------------------------------------
	// Sync outputs
	// ---------------------------------------------------------------
	lps_sync_out u_sync_out (
		.i_core_clk      (i_core_clk),
		.i_rst           (i_rst),
		.i_straps        (straps_s2),
		.i_video         (i_video),
		.o_hsync         (o_hsync),
		.o_vsync         (o_vsync),
		.o_csync         (o_csync),
		.o_cblank        (o_cblank),
		.o_sync_on_green (o_sync_on_green)
	);

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb_main @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	a_status_no_side: assert property (
		access && hit_status && !pen_edge |=> $stable(pen_latch))
		else $error("status read changed latch");
	a_mode_bits_mux: assert property (
		rd_act && hit_status |=> o_io_data[0] ==
		($past(i_color_mode) ? $past(i_color_status[0])
		                     : $past(i_mono_status[0])))
		else $error("mode bit zero wrong");
	a_pen_trigger_sets: assert property (
		pen_edge |=> pen_latch)
		else $error("pen trigger did not set latch");
	a_switch_follows: assert property (
		rd_act && hit_status |=> o_io_data[2] == $past(sw_s2))
		else $error("switch bit not live");
	a_pixel_counts: assert property (
		i_pixel_en |=> pix_cnt == $past(pix_cnt) + 4'h1)
		else $error("pixel counter did not advance");
	a_clear_port: assert property (
		access && hit_clear && !pen_edge |=> !pen_latch)
		else $error("clear port did not clear");
	a_set_port: assert property (
		access && hit_set |=> pen_latch)
		else $error("set port did not set");
	a_unused_inert: assert property (
		access && base_hit && offset >= lps_pkg::OFF_UNUSED_LO && !pen_edge
		|=> $stable(pen_latch))
		else $error("unused offset had effect");
	a_default_base: assert property (
		straps_s2.base_cut == 4'h0 |-> mono_base == 10'h3b0 &&
		color_base == 10'h3d0)
		else $error("default base wrong");
	a_all_cut_base: assert property (
		straps_s2.base_cut == 4'hf |-> mono_base == 10'h020)
		else $error("strap cut base wrong");
	a_capture_hold: assert property (
		pen_latch && !(access && hit_clear) |=> $stable(pen_pos))
		else $error("pen position not held");
	a_capture_take: assert property (
		pen_edge && !pen_latch |=> pen_pos == $past(pix_cnt))
		else $error("pen position not captured");

	c_pen_hit: cover property (pen_edge ##[1:20] (access && hit_clear));
	c_status_read: cover property (o_io_data_oe && o_io_data[1]);
	c_set_port: cover property (access && hit_set && !pen_latch);
	c_alt_base: cover property (access && straps_s2.base_cut != 4'h0);

endmodule : lps_status_ports
`default_nettype wire

/* File: logic/lps_pkg.sv */
/*
 * Constants and carrier types for the light pen status ports.
 * Assumes a ten-bit host I/O address and four-bit register offsets.
 */
`default_nettype none
package lps_pkg;
	// ---------------------------------------------------------------
	// Register offsets from the I/O base
	// ---------------------------------------------------------------
	localparam logic [3:0] OFF_STATUS      = 4'ha;
	localparam logic [3:0] OFF_PEN_CLEAR   = 4'hb;
	localparam logic [3:0] OFF_PEN_SET     = 4'hc;
	localparam logic [3:0] OFF_UNUSED_LO   = 4'hd;
	localparam logic [3:0] OFF_UNUSED_HI   = 4'hf;

	// ---------------------------------------------------------------
	// Base address decode
	// ---------------------------------------------------------------
	localparam logic [9:0] MONO_BASE_DFLT  = 10'h3b0;
	localparam logic [9:0] COLOR_DELTA     = 10'h020;
	localparam logic [9:0] CUT_WEIGHT_1    = 10'h010;
	localparam logic [9:0] CUT_WEIGHT_2    = 10'h080;
	localparam logic [9:0] CUT_WEIGHT_3    = 10'h100;
	localparam logic [9:0] CUT_WEIGHT_4    = 10'h200;

	// ---------------------------------------------------------------
	// Status field positions and reset values
	// ---------------------------------------------------------------
	localparam int         ST_MODE_LO      = 0;
	localparam int         ST_PEN_LATCH    = 1;
	localparam int         ST_PEN_SWITCH   = 2;
	localparam int         ST_MODE_HI      = 3;
	localparam int         ST_PIX_LSB      = 4;
	localparam logic       PEN_LATCH_RST   = 1'b0;
	localparam logic [3:0] PIX_CNT_RST     = 4'h0;
	localparam logic [7:0] IO_DATA_RST     = 8'h00;

	// Strap settings, all zero means factory default
	typedef struct packed {
		logic [3:0] base_cut;
		logic       hs_inv;
		logic       vs_inv;
		logic       cs_inv;
		logic       cs_ext;
		logic       cb_ext;
		logic       sog_off;
	} lps_straps_s;

	localparam lps_straps_s STRAPS_RST = '0;

	// Raw sync sources, all active high
	typedef struct packed {
		logic hsync;
		logic vsync;
		logic csync_int;
		logic csync_ext;
		logic cblank_int;
		logic cblank_ext;
	} lps_video_s;

	localparam lps_video_s VIDEO_RST = '0;
endpackage : lps_pkg
`default_nettype wire

/* File: logic/lps_sync_out.sv */
/*
 * Sync output stage: polarity, source and sync-on-green selection.
 * Assumes straps arrive synchronised and internal sources share the clock;
 * external composite sources come from pins and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module lps_sync_out (
	input  wire logic               i_core_clk,
	input  wire logic               i_rst,
	input  wire lps_pkg::lps_straps_s i_straps,
	input  wire lps_pkg::lps_video_s  i_video,
	output logic                    o_hsync,
	output logic                    o_vsync,
	output logic                    o_csync,
	output logic                    o_cblank,
	output logic                    o_sync_on_green
);
	logic [1:0] ext_s1;
	logic [1:0] ext_s2;
	logic       cs_sel;
	logic       cb_sel;

	// ---------------------------------------------------------------
	// External source synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ext_s1 <= 2'h0;
			ext_s2 <= 2'h0;
		end else begin
			ext_s1 <= {i_video.csync_ext, i_video.cblank_ext};
			ext_s2 <= ext_s1;
		end
	end

	assign cs_sel = i_straps.cs_ext ? ext_s2[1] : i_video.csync_int;
	assign cb_sel = i_straps.cb_ext ? ext_s2[0] : i_video.cblank_int;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_hsync         <= 1'b0;
			o_vsync         <= 1'b1;
			o_csync         <= 1'b1;
			o_cblank        <= 1'b0;
			o_sync_on_green <= 1'b0;
		end else begin
			o_hsync         <= i_video.hsync ^ i_straps.hs_inv;
			o_vsync         <= ~i_video.vsync ^ i_straps.vs_inv;
			o_csync         <= ~cs_sel ^ i_straps.cs_inv;
			o_cblank        <= cb_sel;
			o_sync_on_green <= cs_sel & ~i_straps.sog_off;
		end
	end

	default clocking cb_clk @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	// First edge after reset still shows the reset level, so skip it
	a_hsync_polarity: assert property (
		!$past(i_rst) |->
		o_hsync == ($past(i_video.hsync) ^ $past(i_straps.hs_inv)))
		else $error("hsync polarity wrong");
	a_sog_gate: assert property (
		$past(i_straps.sog_off) |-> !o_sync_on_green)
		else $error("sync on green not disabled");
endmodule : lps_sync_out
`default_nettype wire

/* File: verif/lps_host_model.sv */
/*
 * Host bus and light pen model for the status ports bench.
 * Assumes the design clock is shared and the caller starts each
 * task just after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module lps_host_model (
	input  wire logic       i_core_clk,
	input  wire logic [7:0] i_io_data,
	input  wire logic       i_io_data_oe,
	output logic      [9:0] o_io_addr,
	output logic            o_io_rd_n,
	output logic            o_io_wr_n,
	output logic            o_pen_trigger
);
	// Idle bus and pen at time zero
	initial begin
		o_io_addr     = 10'h000;
		o_io_rd_n     = 1'b1;
		o_io_wr_n     = 1'b1;
		o_pen_trigger = 1'b0;
	end

	// One access per strobe
	// Strobe and address held until the answer is taken, then a gap
	task automatic access(input logic [9:0] addr, input logic rd,
			output logic [7:0] data, output logic oe);
		o_io_addr = addr;
		o_io_rd_n = ~rd;
		o_io_wr_n = rd;
		repeat (6) @(posedge i_core_clk);
		#1 data = i_io_data;
		oe = i_io_data_oe;
		o_io_rd_n = 1'b1;
		o_io_wr_n = 1'b1;
		o_io_addr = ~addr; // Released address shows no stale value
		repeat (4) @(posedge i_core_clk);
		#1;
	endtask : access

	// Pen hit: one rising edge, then low again
	task automatic pen_pulse();
		o_pen_trigger = 1'b1;
		repeat (4) @(posedge i_core_clk);
		#1 o_pen_trigger = 1'b0;
		repeat (4) @(posedge i_core_clk);
		#1;
	endtask : pen_pulse
endmodule : lps_host_model
`default_nettype wire

/* File: verif/test_light_pen_status_ports.sv */
/*
 * Self-checking bench for the light pen status ports.
 * Assumes the host model drives bus and pen pins; the bench
 * drives the remaining inputs one ns after each rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module test_light_pen_status_ports;
	logic                 clk, rst, pix_en, color, sw_open;
	logic [1:0]           c_st, m_st;
	logic [3:0]           pix;
	logic [7:0]           rd_d, tmp_d;
	logic                 rd_oe;
	logic [9:0]           bse, addr;
	lps_pkg::lps_straps_s straps;
	lps_pkg::lps_video_s  video;
	wire logic            rd_n, wr_n, trig, oe, lat;
	wire logic            hs, vs, cs, cb, sog;
	wire logic [7:0]      d_data;
	wire logic [3:0]      pnib;
	int                   n_errors, compares;

	lps_status_ports u_dut (.i_core_clk(clk), .i_rst(rst),
		.i_io_addr(addr), .i_io_rd_n(rd_n), .i_io_wr_n(wr_n),
		.o_io_data(d_data), .o_io_data_oe(oe), .i_pen_trigger(trig),
		.i_pen_switch_open(sw_open), .i_pixel_en(pix_en),
		.i_color_mode(color), .i_color_status(c_st),
		.i_mono_status(m_st), .i_straps(straps), .i_video(video),
		.o_pen_latched(lat), .o_pen_pixel(pnib), .o_hsync(hs),
		.o_vsync(vs), .o_csync(cs), .o_cblank(cb),
		.o_sync_on_green(sog));

	lps_host_model u_host (.i_core_clk(clk), .i_io_data(d_data),
		.i_io_data_oe(oe), .o_io_addr(addr), .o_io_rd_n(rd_n),
		.o_io_wr_n(wr_n), .o_pen_trigger(trig));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Compare and count
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report

	function automatic logic [9:0] mono_base(input logic [3:0] k);
		logic [9:0] b;
		b = lps_pkg::MONO_BASE_DFLT;
		if (k[0]) b = b - lps_pkg::CUT_WEIGHT_1;
		if (k[1]) b = b - lps_pkg::CUT_WEIGHT_2;
		if (k[2]) b = b - lps_pkg::CUT_WEIGHT_3;
		if (k[3]) b = b - lps_pkg::CUT_WEIGHT_4;
		return b;
	endfunction : mono_base

	function automatic logic [7:0] stat_exp(input logic l);
		logic [1:0] md;
		md = color ? c_st : m_st;
		return {pix, md[1], sw_open, l, md[0]};
	endfunction : stat_exp

	function automatic logic [7:0] sync_exp();
		logic c;
		c = straps.cs_ext ? video.csync_ext : video.csync_int;
		return {3'h0, video.hsync ^ straps.hs_inv,
			~video.vsync ^ straps.vs_inv, ~c ^ straps.cs_inv,
			straps.cb_ext ? video.cblank_ext : video.cblank_int,
			c & ~straps.sog_off};
	endfunction : sync_exp

	// Access, then confirm the data bus is released
	task automatic io(input logic [9:0] a, input logic r);
		u_host.access(a, r, rd_d, rd_oe);
		check({7'h0, oe}, 8'h00);
	endtask : io

	// Status read with fresh mode, status and switch inputs
	task automatic rd_stat(input logic [9:0] a, input logic l);
		color = 1'($urandom);
		c_st = 2'($urandom);
		m_st = 2'($urandom);
		sw_open = 1'($urandom);
		io(a, 1'b1);
		check({7'h0, rd_oe}, 8'h01);
		check(rd_d, stat_exp(l));
	endtask : rd_stat

	task automatic run_pix(input int n);
		repeat (n) begin
			pix_en = 1'($urandom);
			pix = pix + 4'(pix_en);
			@(posedge clk);
			#1;
		end
		pix_en = 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask : run_pix

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_n

	// Watchdog against a hang
	initial begin
		#1ms;
		n_errors++;
		final_report();
	end

	initial begin
		n_errors = 0;
		compares = 0;
		rst = 1'b1;
		pix_en = 1'b0;
		color = 1'b0;
		sw_open = 1'b1;
		c_st = 2'h0;
		m_st = 2'h0;
		pix = 4'h0;
		straps = lps_pkg::STRAPS_RST;
		video = lps_pkg::VIDEO_RST;
		tmp_d = 8'($urandom(36266));
		wait_n(4);
		check({oe, lat, vs, cs, sog}, 8'h06);
		rst = 1'b0;
		wait_n(4);
		// Default bases, both pen latch states, capture on hit
		rd_stat(10'h3ba, 1'b0);
		rd_stat(10'h3da, 1'b0);
		run_pix(20 + ($urandom % 20));
		u_host.pen_pulse();
		check({7'h0, lat}, 8'h01);
		check({4'h0, pnib}, {4'h0, pix});
		rd_stat(10'h3ba, 1'b1);
		rd_stat(10'h3da, 1'b1);
		io(10'h3da, 1'b0);
		rd_stat(10'h3ba, 1'b1);
		$display("test defaults done");
		// Clear and set ports, read and write access
		for (int i = 0; i < 8; i++) begin
			bse = i[2] ? 10'h3d0 : 10'h3b0;
			io(bse + (i[0] ? 10'h00c : 10'h00b), i[1]);
			check({7'h0, rd_oe}, 8'h00);
			check({7'h0, lat}, {7'h0, i[0]});
		end
		$display("test clear set done");
		// Capture held while latched, new capture after clear
		tmp_d = {4'h0, pix};
		run_pix(20);
		u_host.pen_pulse();
		check({4'h0, pnib}, tmp_d);
		io(10'h3bb, 1'b0);
		check({7'h0, lat}, 8'h00);
		u_host.pen_pulse();
		check({4'h0, pnib}, {4'h0, pix});
		$display("test capture done");
		// Unused offsets leave the latch alone
		for (int i = 0; i < 12; i++) begin
			io(10'h3bd + 10'(i % 3) + (i[2] ? 10'h020 : 10'h000), i[0]);
			check({rd_oe, lat}, 8'h01);
		end
		$display("test unused done");
		// Every base cut strap setting, with one base of its pair picked at random
		for (int k = 0; k < 16; k++) begin
			straps.base_cut = 4'(k);
			wait_n(4);
			bse = mono_base(4'(k)) + ($urandom % 2 ? 10'h020 : 10'h000);
			io(bse + 10'h04b, 1'($urandom));
			check({7'h0, lat}, 8'h01);
			rd_stat(bse + 10'h00a, 1'b1);
			io(bse + 10'h00b, 1'($urandom));
			check({7'h0, lat}, 8'h00);
			io(bse + 10'h00c, 1'($urandom));
			check({7'h0, lat}, 8'h01);
		end
		$display("test bases done");
		// Sync polarity and source straps
		for (int i = 0; i < 12; i++) begin
			straps = lps_pkg::lps_straps_s'(10'($urandom));
			straps.base_cut = 4'h0;
			video = lps_pkg::lps_video_s'(6'($urandom));
			wait_n(6);
			check({3'h0, hs, vs, cs, cb, sog}, sync_exp());
		end
		$display("test sync done");
		// Reset in mid-run clears a set latch
		rst = 1'b1;
		wait_n(2);
		check({7'h0, lat}, 8'h00);
		rst = 1'b0;
		wait_n(4);
		$display("test reset done");
		final_report();
	end
endmodule : test_light_pen_status_ports
`default_nettype wire
